//--- common/rmdp_pkg.sv
// Purpose: shared constants and types for the return mode descriptor parser
// Assumes: byte-wide input stream, one clock domain
// Notes:   field widths and byte counts shared by the parser live here; bit slices are coded in the parser
package rmdp_pkg;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W       = 8;   // stream byte width
  localparam int unsigned SCRAMBLE_W   = 18;  // scrambler seed selector width
  localparam int unsigned PUNCT_W      = 4;   // code rate pattern width
  localparam int unsigned MODSEL_W     = 5;   // modulation/spreading selector width
  localparam int unsigned SNR_W        = 7;   // signed half-dB limit width
  localparam int unsigned SCR_HI_W     = 2;   // seed bits carried in first seed byte

  // mode record layout pushed into the fifo:
  // {frame_group_id, seed, punct, modsel, slot_kind, valid, snr}
  localparam int unsigned MODE_W = BYTE_W + SCRAMBLE_W + PUNCT_W + MODSEL_W
                                   + BYTE_W + 1 + SNR_W;
  localparam int unsigned FIFO_DEPTH = 8;     // mode words buffered

  // ----------------------------------------------------------------
  // reset values and byte counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_ZERO      = 8'h00;  // cleared counters
  localparam logic [7:0] GROUP_HDR_LEN = 8'h05;  // id + 3 seed bytes + mode total
  localparam logic [7:0] MODE_LEN      = 8'h04;  // bytes in one mode entry
  localparam logic [7:0] ONE_BYTE      = 8'h01;  // unit step

  // ----------------------------------------------------------------
  // parser states
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    RMDP_IDLE   = 11'h001,  // awaiting record type
    RMDP_LEN    = 11'h002,  // record byte count
    RMDP_LOOPS  = 11'h004,  // frame group loop total
    RMDP_FGID   = 11'h008,  // frame group identifier
    RMDP_SEED0  = 11'h010,  // 6 reserved + seed[17:16]
    RMDP_SEED1  = 11'h020,  // seed[15:8]
    RMDP_SEED2  = 11'h040,  // seed[7:0]
    RMDP_MCNT   = 11'h080,  // mode entry total
    RMDP_PUNCT  = 11'h100,  // 4 reserved + code rate pattern
    RMDP_MODSEL = 11'h200,  // 3 reserved + modulation selector
    RMDP_KIND   = 11'h400   // slot kind, then flag+limit byte follows
  } rmdp_state_e;

endpackage : rmdp_pkg

//--- common/rmdp_mode_if.sv
// Purpose: carries mode records from the parser core into its fifo
// Assumes: single clock, valid/ready handshake
// Notes:   data is one packed mode record
`timescale 1ns/1ps
interface rmdp_mode_if;
  logic                       valid;  // record offered
  logic                       ready;  // record accepted
  logic [rmdp_pkg::MODE_W-1:0] data;  // packed mode record

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rmdp_mode_if

//--- hdl/rmdp_fifo.sv
// Purpose: small synchronous fifo for parsed mode records
// Assumes: one clock, asynchronous active-high reset
// Notes:   read data comes from a register; depth must be a power of two
`timescale 1ns/1ps
module rmdp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // flush clears all content
  input  wire logic             i_flush,
  // fill side
  rmdp_mode_if.snk              wr,
  // drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];  // entries
  logic [AW:0]      wptr;         // write pointer with wrap bit
  logic [AW:0]      rptr;         // read pointer with wrap bit
  logic [AW:0]      next_rptr;    // read pointer after a pop

  wire full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire push  = wr.valid && !full;
  // output register refills whenever it is empty or being drained
  wire load  = !empty && (!o_valid || i_ready);

  assign wr.ready  = !full;
  assign next_rptr = rptr + {{AW{1'b0}}, 1'b1};

  // write port
  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem[wptr[AW-1:0]] <= wr.data;
  end

  // pointers and registered read data
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wptr    <= '0;
      rptr    <= '0;
      o_valid <= 1'b0;
      o_data  <= '0;
    end
    else if (i_flush)
    begin
      wptr    <= '0;
      rptr    <= '0;
      o_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wptr <= wptr + {{AW{1'b0}}, 1'b1};
      if (load)
      begin
        o_data  <= mem[rptr[AW-1:0]];
        o_valid <= 1'b1;
        rptr    <= next_rptr;
      end
      else if (i_ready)
        o_valid <= 1'b0;
    end
  end
endmodule : rmdp_fifo

//--- hdl/rmdp_parser.sv
// Purpose: parse the return mode list descriptor from a byte stream
// Assumes: bytes are synchronous to i_core_clk, one per valid cycle
// Notes:   modes are buffered; a length mismatch discards the record's modes
//
// How it works
// - read type byte then record byte count
// - loop total sets number of frame groups
// - group id, 6 reserved, 18-bit seed
// - mode total sets inner entries per group
// - 4 reserved then 4-bit code rate
// - 3 reserved then 5-bit modulation selector
// - 8-bit slot content kind follows
// - 1-bit flag marks limit valid
// - 7-bit signed half-dB snr limit
// - limit ignored when flag is zero
// - list applies to continuous transmission only
// - reserved bits lead and are discarded
`timescale 1ns/1ps
module rmdp_parser (
  // clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  // incoming descriptor byte stream
  input  wire logic                         i_byte_valid,
  output logic                              o_byte_ready,
  input  wire logic [7:0]                   i_byte,
  // terminal state
  input  wire logic                         i_continuous_mode,
  // parsed mode output
  output logic                              o_mode_valid,
  input  wire logic                         i_mode_ready,
  output logic [7:0]                        o_frame_group_identifier,
  output logic [rmdp_pkg::SCRAMBLE_W-1:0]   o_scrambler_seed,
  output logic [rmdp_pkg::PUNCT_W-1:0]      o_code_rate,
  output logic [rmdp_pkg::MODSEL_W-1:0]     o_modulation_sel,
  output logic [7:0]                        o_slot_content_kind,
  output logic                              o_snr_limit_valid,
  output logic signed [rmdp_pkg::SNR_W-1:0] o_snr_limit_value,
  // record status
  output logic [7:0]                        o_record_type,
  output logic                              o_record_done,
  output logic                              o_length_error
);

  // ----------------------------------------------------------------
  // parser state
  // ----------------------------------------------------------------
  rmdp_pkg::rmdp_state_e state;        // current field
  rmdp_pkg::rmdp_state_e next_state;   // field after this byte
  logic                  snr_phase;    // last byte of a mode entry
  logic [7:0]            rec_len;      // record byte count
  logic [7:0]            consumed;     // bytes seen after the count
  logic [7:0]            groups_left;  // outer iterations remaining
  logic [7:0]            modes_left;   // inner iterations remaining
  logic [7:0]            fgid;         // current frame group identifier
  logic [rmdp_pkg::SCRAMBLE_W-1:0] seed; // current scrambler seed
  logic [rmdp_pkg::PUNCT_W-1:0]    punct;  // code rate of entry
  logic [rmdp_pkg::MODSEL_W-1:0]   modsel; // modulation of entry
  logic [7:0]            kind;         // slot kind of entry
  logic                  hold_ok;      // modes of this record still good
  logic                  gate_open;    // record released to the consumer

  // fifo link and its drain side
  rmdp_mode_if mode_link ();
  logic                           fifo_valid;  // record ready at fifo head
  logic [rmdp_pkg::MODE_W-1:0]    fifo_data;   // head record
  logic                           flush;       // drop buffered modes

  // ----------------------------------------------------------------
  // byte acceptance and decode
  // ----------------------------------------------------------------
  // the snr byte pushes a record, so it waits for fifo room
  assign o_byte_ready = !(snr_phase && !mode_link.ready);
  wire take      = i_byte_valid && o_byte_ready;
  wire in_body   = (state != rmdp_pkg::RMDP_IDLE) && (state != rmdp_pkg::RMDP_LEN);
  wire in_record = in_body || snr_phase;
  wire [7:0] consumed_n = consumed + rmdp_pkg::ONE_BYTE;
  // record ends on the last entry of the last group or when no loops remain
  wire last_mode = (modes_left == rmdp_pkg::ONE_BYTE);
  wire last_grp  = (groups_left == rmdp_pkg::ONE_BYTE);
  wire grp_end   = snr_phase && last_mode;
  wire rec_end   = take && ((snr_phase && last_mode && last_grp)
                 || (state == rmdp_pkg::RMDP_LOOPS && i_byte == rmdp_pkg::CNT_ZERO)
                 || (state == rmdp_pkg::RMDP_MCNT && i_byte == rmdp_pkg::CNT_ZERO
                     && last_grp));
  // loops must consume exactly the byte count
  wire len_bad   = (consumed_n != rec_len);
  // also bad if the count runs out before the loops end
  wire overrun   = take && in_record && !rec_end && (consumed_n == rec_len);

  // flag bit at msb, signed limit below it; limit forced to zero when unflagged
  wire       snr_flag = i_byte[7];
  wire [6:0] snr_val  = snr_flag ? i_byte[6:0] : 7'h00;

  // record pushed on the final byte of each entry while hold_ok is set, only in continuous mode
  assign mode_link.valid = take && snr_phase && hold_ok && i_continuous_mode;
  assign mode_link.data  = {fgid, seed, punct, modsel, kind, snr_flag, snr_val};

  // ----------------------------------------------------------------
  // next field selection
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      rmdp_pkg::RMDP_IDLE:   next_state = rmdp_pkg::RMDP_LEN;
      rmdp_pkg::RMDP_LEN:    next_state = rmdp_pkg::RMDP_LOOPS;
      rmdp_pkg::RMDP_LOOPS:
        next_state = (i_byte == rmdp_pkg::CNT_ZERO) ? rmdp_pkg::RMDP_IDLE
                                                    : rmdp_pkg::RMDP_FGID;
      rmdp_pkg::RMDP_FGID:   next_state = rmdp_pkg::RMDP_SEED0;
      rmdp_pkg::RMDP_SEED0:  next_state = rmdp_pkg::RMDP_SEED1;
      rmdp_pkg::RMDP_SEED1:  next_state = rmdp_pkg::RMDP_SEED2;
      rmdp_pkg::RMDP_SEED2:  next_state = rmdp_pkg::RMDP_MCNT;
      rmdp_pkg::RMDP_MCNT:
        if (i_byte != rmdp_pkg::CNT_ZERO)
          next_state = rmdp_pkg::RMDP_PUNCT;
        else if (last_grp)
          next_state = rmdp_pkg::RMDP_IDLE;
        else
          next_state = rmdp_pkg::RMDP_FGID;
      rmdp_pkg::RMDP_PUNCT:  next_state = rmdp_pkg::RMDP_MODSEL;
      rmdp_pkg::RMDP_MODSEL: next_state = rmdp_pkg::RMDP_KIND;
      rmdp_pkg::RMDP_KIND:   next_state = rmdp_pkg::RMDP_KIND;   // snr byte next
      default:               next_state = rmdp_pkg::RMDP_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state and loop counters
  // ----------------------------------------------------------------
  // the snr byte is a sub-phase of the kind state to keep the enum one-hot
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state       <= rmdp_pkg::RMDP_IDLE;
      snr_phase   <= 1'b0;
      groups_left <= rmdp_pkg::CNT_ZERO;
      modes_left  <= rmdp_pkg::CNT_ZERO;
    end
    else if (take)
    begin
      if (snr_phase)
      begin
        // end of one mode entry
        snr_phase  <= 1'b0;
        modes_left <= modes_left - rmdp_pkg::ONE_BYTE;
        if (grp_end)
        begin
          groups_left <= groups_left - rmdp_pkg::ONE_BYTE;
          state <= last_grp ? rmdp_pkg::RMDP_IDLE : rmdp_pkg::RMDP_FGID;
        end
        else
          state <= rmdp_pkg::RMDP_PUNCT;
      end
      else if (state == rmdp_pkg::RMDP_KIND)
        snr_phase <= 1'b1;
      else
      begin
        state <= next_state;
        if (state == rmdp_pkg::RMDP_LOOPS)
          groups_left <= i_byte;
        if (state == rmdp_pkg::RMDP_MCNT)
        begin
          modes_left <= i_byte;
          if (i_byte == rmdp_pkg::CNT_ZERO)
            groups_left <= groups_left - rmdp_pkg::ONE_BYTE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // field capture; reserved high bits are dropped unchecked
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_record_type <= rmdp_pkg::CNT_ZERO;
      rec_len       <= rmdp_pkg::CNT_ZERO;
      fgid          <= rmdp_pkg::CNT_ZERO;
      seed          <= '0;
      punct         <= '0;
      modsel        <= '0;
      kind          <= rmdp_pkg::CNT_ZERO;
    end
    else if (take && !snr_phase)
    begin
      case (state)
        rmdp_pkg::RMDP_IDLE:   o_record_type <= i_byte;
        rmdp_pkg::RMDP_LEN:    rec_len <= i_byte;
        rmdp_pkg::RMDP_FGID:   fgid <= i_byte;
        rmdp_pkg::RMDP_SEED0:  seed[17:16] <= i_byte[rmdp_pkg::SCR_HI_W-1:0];
        rmdp_pkg::RMDP_SEED1:  seed[15:8] <= i_byte;
        rmdp_pkg::RMDP_SEED2:  seed[7:0] <= i_byte;
        rmdp_pkg::RMDP_PUNCT:  punct <= i_byte[3:0];
        rmdp_pkg::RMDP_MODSEL: modsel <= i_byte[4:0];
        rmdp_pkg::RMDP_KIND:   kind <= i_byte;
        default:               ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // length accounting and release
  // ----------------------------------------------------------------
  // modes sit in the fifo until the record closes with a good count,
  // so a bad record never reaches the consumer
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      consumed       <= rmdp_pkg::CNT_ZERO;
      hold_ok        <= 1'b1;
      gate_open      <= 1'b0;
      o_record_done  <= 1'b0;
      o_length_error <= 1'b0;
      flush          <= 1'b0;
    end
    else
    begin
      o_record_done <= rec_end;
      flush         <= 1'b0;
      if (take && state == rmdp_pkg::RMDP_IDLE && !snr_phase)
      begin
        // new record: clear accounting and the error shown for the last
        consumed       <= rmdp_pkg::CNT_ZERO;
        hold_ok        <= 1'b1;
        o_length_error <= 1'b0;
      end
      else if (take && in_record)
        consumed <= consumed_n;
      if (overrun)
        hold_ok <= 1'b0;
      if (rec_end)
      begin
        if (len_bad || !hold_ok)
        begin
          o_length_error <= 1'b1;
          flush          <= 1'b1;
          gate_open      <= 1'b0;
        end
        else
          gate_open <= 1'b1;
      end
      else if (take && state == rmdp_pkg::RMDP_IDLE && !snr_phase)
        gate_open <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode buffer
  // ----------------------------------------------------------------
  rmdp_fifo #(
    .WIDTH (rmdp_pkg::MODE_W),
    .DEPTH (rmdp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_flush    (flush),
    .wr         (mode_link),
    .o_valid    (fifo_valid),
    .i_ready    (i_mode_ready && gate_open),
    .o_data     (fifo_data)
  );

  // fields of the head record; valid only once the record is released
  assign o_mode_valid = fifo_valid && gate_open;
  assign {o_frame_group_identifier, o_scrambler_seed, o_code_rate, o_modulation_sel,
          o_slot_content_kind, o_snr_limit_valid, o_snr_limit_value} = fifo_data;

endmodule : rmdp_parser

//--- dv/rmdp_parser_properties.sv
// Purpose: port-level checks on the descriptor parser
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound into every rmdp_parser instance
`timescale 1ns/1ps
module rmdp_parser_props (
  // clock and reset
  input wire logic                                i_core_clk,
  input wire logic                                i_rst,
  // stream side
  input wire logic                                i_byte_valid,
  input wire logic                                o_byte_ready,
  // mode side
  input wire logic                                o_mode_valid,
  input wire logic                                i_mode_ready,
  input wire logic [rmdp_pkg::SCRAMBLE_W-1:0]     o_scrambler_seed,
  input wire logic [7:0]                          o_slot_content_kind,
  input wire logic                                o_snr_limit_valid,
  input wire logic signed [rmdp_pkg::SNR_W-1:0]   o_snr_limit_value,
  // record status
  input wire logic [7:0]                          o_record_type,
  input wire logic                                o_record_done,
  input wire logic                                o_length_error
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // a stream byte is consumed at this edge
  wire take = i_byte_valid && o_byte_ready;

  chk_idle_after_reset: assert property ($fell(i_rst) |-> o_byte_ready && !o_mode_valid)
    else $error("parser not idle after reset");
  chk_done_pulse: assert property (o_record_done |=> !o_record_done)
    else $error("record done longer than one cycle");
  chk_type_stable: assert property (!take |=> $stable(o_record_type))
    else $error("record type moved without a byte");
  chk_err_on_done: assert property ($rose(o_length_error) |-> o_record_done)
    else $error("length error raised outside record end");
  chk_err_holds: assert property (o_length_error && !i_byte_valid |=> o_length_error)
    else $error("length error dropped while stream idle");
  chk_err_no_modes: assert property (o_length_error |-> !o_mode_valid)
    else $error("modes offered after a length error");
  chk_snr_unused: assert property (o_mode_valid && !o_snr_limit_valid |-> o_snr_limit_value == 7'h00)
    else $error("limit value shown while flag clear");
  // a stalled head must keep its seed and kind; a type byte may withdraw it
  chk_head_stable: assert property (o_mode_valid && !i_mode_ready |=>
    $stable(o_scrambler_seed) && $stable(o_slot_content_kind))
    else $error("stalled mode record changed");
  chk_valid_hold: assert property (o_mode_valid && !i_mode_ready && !i_byte_valid |=> o_mode_valid)
    else $error("mode offer withdrawn without cause");

  // main scenarios
  cov_good_rec: cover property (o_record_done && !o_length_error);
  cov_bad_rec: cover property (o_record_done && o_length_error);
  cov_mode_taken: cover property (o_mode_valid && i_mode_ready && o_snr_limit_valid);
endmodule : rmdp_parser_props

bind rmdp_parser rmdp_parser_props u_props (.i_core_clk, .i_rst, .i_byte_valid, .o_byte_ready,
  .o_mode_valid, .i_mode_ready, .o_scrambler_seed, .o_slot_content_kind, .o_snr_limit_valid,
  .o_snr_limit_value, .o_record_type, .o_record_done, .o_length_error);

//--- dv/rmdp_src_model.sv
// Purpose: signalling source that streams descriptor bytes
// Assumes: bytes are queued by the bench through push
// Notes:   i_gap idle cycles follow each byte to model a slow source
`timescale 1ns/1ps
module rmdp_src_model (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // stream
  output logic            o_byte_valid,
  input  wire logic       i_byte_ready,
  output logic [7:0]      o_byte,
  // pacing
  input  wire logic [3:0] i_gap
);
  // ----------------------------------------------------------------
  // byte queue and pacing
  // ----------------------------------------------------------------
  logic [7:0] q[$];  // bytes still to send
  int         gap_n; // idle cycles left

  // the bench queues every byte here in order, in either transmission mode
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  // hold an offer until taken; idle data toggles so nothing stale looks valid
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_byte_valid <= 1'b0;
      o_byte       <= 8'h00;
      gap_n        <= 0;
    end
    else if (o_byte_valid && !i_byte_ready)
      o_byte_valid <= 1'b1;
    else if (q.size() > 0 && gap_n == 0)
    begin
      o_byte_valid <= 1'b1;
      o_byte       <= q.pop_front();
      gap_n        <= int'(i_gap);
    end
    else
    begin
      o_byte_valid <= 1'b0;
      o_byte       <= ~o_byte;
      if (gap_n > 0)
        gap_n <= gap_n - 1;
    end
  end
endmodule : rmdp_src_model

//--- dv/tb_top.sv
// Purpose: directed test of the descriptor parser
// Assumes: one record in flight at a time
// Notes:   expected modes are built alongside the stimulus bytes
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                              i_core_clk = 1'b0;
  logic                              i_rst = 1'b1;
  logic                              i_byte_valid;
  logic                              o_byte_ready;
  logic [7:0]                        i_byte;
  logic                              i_continuous_mode = 1'b1;
  logic                              o_mode_valid;
  logic                              i_mode_ready = 1'b0;
  logic [7:0]                        o_frame_group_identifier;
  logic [rmdp_pkg::SCRAMBLE_W-1:0]   o_scrambler_seed;
  logic [rmdp_pkg::PUNCT_W-1:0]      o_code_rate;
  logic [rmdp_pkg::MODSEL_W-1:0]     o_modulation_sel;
  logic [7:0]                        o_slot_content_kind;
  logic                              o_snr_limit_valid;
  logic signed [rmdp_pkg::SNR_W-1:0] o_snr_limit_value;
  logic [7:0]                        o_record_type;
  logic                              o_record_done;
  logic                              o_length_error;
  logic [3:0]                        gap = 4'h0;   // source pacing
  logic                              keep = 1'b1;  // modes expected out
  logic [rmdp_pkg::MODE_W-1:0]       exp_q[$];     // expected records
  int                                err_count = 0;
  int                                cmp_count = 0;

  always #4 i_core_clk = ~i_core_clk;

  rmdp_parser dut (.i_core_clk, .i_rst, .i_byte_valid, .o_byte_ready, .i_byte,
    .i_continuous_mode, .o_mode_valid, .i_mode_ready, .o_frame_group_identifier,
    .o_scrambler_seed, .o_code_rate, .o_modulation_sel, .o_slot_content_kind,
    .o_snr_limit_valid, .o_snr_limit_value, .o_record_type, .o_record_done, .o_length_error);

  rmdp_src_model src (.i_core_clk, .i_rst, .o_byte_valid(i_byte_valid),
    .i_byte_ready(o_byte_ready), .o_byte(i_byte), .i_gap(gap));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // record header: type, byte count, frame group loop total
  task hdr(input logic [7:0] typ, input logic [7:0] cnt, input logic [7:0] loops);
    src.push(typ);
    src.push(cnt);
    src.push(loops);
  endtask : hdr

  // one frame group; reserved bits set to nonzero junk to prove they are dropped
  task add_group(input logic [7:0] fg, input logic [17:0] sd, input logic [7:0] nm,
                 input logic [7:0] base);
    logic [7:0] m;
    logic [6:0] sn;
    src.push(fg);
    src.push({6'h2B, sd[17:16]});
    src.push(sd[15:8]);
    src.push(sd[7:0]);
    src.push(nm);
    for (int i = 0; i < int'(nm); i++)
    begin
      m  = base + 8'(i);
      sn = 7'h40 + m[6:0];  // negative limits exercise the sign bit
      src.push({4'h9, m[3:0]});
      src.push({3'h6, m[4:0]});
      src.push(8'hC0 ^ m);
      src.push({m[0], sn});
      if (keep)
        exp_q.push_back({fg, sd, m[3:0], m[4:0], 8'hC0 ^ m, m[0], m[0] ? sn : 7'h00});
    end
  endtask : add_group

  // wait for record end, then drain and compare every expected mode
  task run_rec(input logic [7:0] typ, input logic exp_err);
    int n;
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (o_record_done !== 1'b1 && n < 3000);
    chk(o_record_done, 1'b1);
    chk(o_length_error, exp_err);
    chk(o_record_type, typ);
    while (exp_q.size() > 0)
    begin
      n = 0;
      while (o_mode_valid !== 1'b1 && n < 500)
      begin
        @(posedge i_core_clk);
        n++;
      end
      chk({o_frame_group_identifier, o_scrambler_seed, o_code_rate, o_modulation_sel,
           o_slot_content_kind, o_snr_limit_valid, o_snr_limit_value},
          exp_q.pop_front());
      i_mode_ready <= 1'b1;
      @(posedge i_core_clk);
      i_mode_ready <= 1'b0;
      @(posedge i_core_clk);
    end
    repeat (2) @(posedge i_core_clk);
    chk(o_mode_valid, 1'b0);
  endtask : run_rec

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // one group, two modes, limit valid and not
    hdr(8'h71, 8'h0E, 8'h01);
    add_group(8'h5A, 18'h2ABCD, 8'h02, 8'h05);
    run_rec(8'h71, 1'b0);
    // slow source, two groups, the second with no modes
    gap <= 4'h3;
    hdr(8'h72, 8'h0F, 8'h02);
    add_group(8'h11, 18'h3FFFF, 8'h01, 8'h1E);
    add_group(8'h12, 18'h00001, 8'h00, 8'h00);
    run_rec(8'h72, 1'b0);
    gap <= 4'h0;
    // eight modes back to back are all held before release: seven in the fifo, one in its output register
    hdr(8'h73, 8'h26, 8'h01);
    add_group(8'h20, 18'h15555, 8'h08, 8'h08);
    run_rec(8'h73, 1'b0);
    // byte count one short and one long: modes dropped
    keep = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      hdr(8'h74, k == 0 ? 8'h0D : 8'h0F, 8'h01);
      add_group(8'h30, 18'h00000, 8'h02, 8'h00);
      run_rec(8'h74, 1'b1);
    end
    // empty loop clears the error
    hdr(8'h75, 8'h01, 8'h00);
    run_rec(8'h75, 1'b0);
    // burst mode: list is not taken
    i_continuous_mode <= 1'b0;
    hdr(8'h76, 8'h0E, 8'h01);
    add_group(8'h40, 18'h12345, 8'h02, 8'h03);
    run_rec(8'h76, 1'b0);
    end_sim();
  end

  // watchdog sized well beyond the longest run
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule : tb_top
